// [rtl/rtc_window_pkg.sv]
package rtc_window_pkg;

    // Register word indices; the byte address is four times the index.
    localparam int IDX_ALARM_LOW  = 32'h0000_0F8E;
    localparam int IDX_ALARM_HIGH = 32'h0000_0F8F;
    localparam int IDX_TIME_LOW   = 32'h0000_0F98;
    localparam int IDX_TIME_HIGH  = 32'h0000_0F99;
    localparam int IDX_CONTROL    = 32'h0000_0F80;
    localparam int BYTES_PER_WORD = 4;
    localparam int MIN_ADDR_W     = 14;

    // Window pointer codes.
    localparam logic [1:0] PTR_00 = 2'h0;
    localparam logic [1:0] PTR_01 = 2'h1;
    localparam logic [1:0] PTR_10 = 2'h2;
    localparam logic [1:0] PTR_11 = 2'h3;

    // Control register field positions.
    localparam int CTL_TPTR_LSB   = 0;
    localparam int CTL_APTR_LSB   = 2;
    localparam int CTL_UNLOCK_BIT = 4;

    // Reset values of control state and of the stored value bytes.
    localparam logic [1:0] PTR_RESET    = 2'h0;
    localparam logic       UNLOCK_RESET = 1'h0;
    localparam logic [7:0] VALUE_RESET  = 8'h00;

    // Storage slots behind the windows.
    localparam int NUM_SLOTS = 11;
    localparam logic [3:0] SLOT_SECOND   = 4'h0;
    localparam logic [3:0] SLOT_MINUTE   = 4'h1;
    localparam logic [3:0] SLOT_HOUR     = 4'h2;
    localparam logic [3:0] SLOT_WEEKDAY  = 4'h3;
    localparam logic [3:0] SLOT_DAY      = 4'h4;
    localparam logic [3:0] SLOT_MONTH    = 4'h5;
    localparam logic [3:0] SLOT_YEAR     = 4'h6;
    localparam logic [3:0] SLOT_A_HOUR   = 4'h7;
    localparam logic [3:0] SLOT_A_WEEKDAY = 4'h8;
    localparam logic [3:0] SLOT_A_DAY    = 4'h9;
    localparam logic [3:0] SLOT_A_MONTH  = 4'hA;

    // Implemented bits of each slot, indexed by slot number.
    localparam logic [7:0] MASK_SECOND  = 8'h7F;
    localparam logic [7:0] MASK_MINUTE  = 8'h7F;
    localparam logic [7:0] MASK_HOUR    = 8'h3F;
    localparam logic [7:0] MASK_WEEKDAY = 8'h07;
    localparam logic [7:0] MASK_DAY     = 8'h3F;
    localparam logic [7:0] MASK_MONTH   = 8'h1F;
    localparam logic [7:0] MASK_YEAR    = 8'hFF;
    localparam logic [10:0][7:0] SLOT_MASK = {MASK_MONTH, MASK_DAY, MASK_WEEKDAY, MASK_HOUR,
                                              MASK_YEAR, MASK_MONTH, MASK_DAY, MASK_WEEKDAY,
                                              MASK_HOUR, MASK_MINUTE, MASK_SECOND};

endpackage

// [rtl/rtc_value_window.sv]
`timescale 1ns/1ps
module rtc_value_window #(
    parameter int ADDR_W = 14
) (
    input  wire logic              clock,
    input  wire logic              reset,
    input  wire logic [ADDR_W-1:0] address,
    input  wire logic              read,
    input  wire logic              write,
    input  wire logic [31:0]       writedata,
    input  wire logic [3:0]        byteenable,
    output logic      [31:0]       readdata,
    output logic                   waitrequest
);

    // The windows sit above the control word, so narrower buses cannot reach them.
    if (ADDR_W < rtc_window_pkg::MIN_ADDR_W) begin : g_addr_check
        $error("ADDR_W too small for the register map.");
    end

    localparam logic [ADDR_W-1:0] ADDR_ALARM_LOW  =
        ADDR_W'(rtc_window_pkg::IDX_ALARM_LOW * rtc_window_pkg::BYTES_PER_WORD);
    localparam logic [ADDR_W-1:0] ADDR_ALARM_HIGH =
        ADDR_W'(rtc_window_pkg::IDX_ALARM_HIGH * rtc_window_pkg::BYTES_PER_WORD);
    localparam logic [ADDR_W-1:0] ADDR_TIME_LOW   =
        ADDR_W'(rtc_window_pkg::IDX_TIME_LOW * rtc_window_pkg::BYTES_PER_WORD);
    localparam logic [ADDR_W-1:0] ADDR_TIME_HIGH  =
        ADDR_W'(rtc_window_pkg::IDX_TIME_HIGH * rtc_window_pkg::BYTES_PER_WORD);
    localparam logic [ADDR_W-1:0] ADDR_CONTROL    =
        ADDR_W'(rtc_window_pkg::IDX_CONTROL * rtc_window_pkg::BYTES_PER_WORD);

    logic        waitrequest_ff;
    logic [31:0] readdata_ff;
    logic [1:0]  time_window_pointer_ff;
    logic [1:0]  alarm_window_pointer_ff;
    logic        value_write_unlock_ff;
    logic [7:0]  value_ff [0:rtc_window_pkg::NUM_SLOTS-1];

    logic        access_done;
    logic        write_done;
    logic        slot_hit;
    logic [3:0]  slot_sel;
    logic [31:0] nxt_readdata;
    logic [1:0]  nxt_time_window_pointer;
    logic [1:0]  nxt_alarm_window_pointer;
    logic [7:0]  wr_byte;

    assign readdata    = readdata_ff;
    assign waitrequest = waitrequest_ff;

    // Only the low byte lane reaches the value bytes and the control fields.
    assign wr_byte     = writedata[7:0];

    // A request completes at the edge where the slave already shows waitrequest low.
    assign access_done = (read || write) && !waitrequest_ff;
    assign write_done  = write && !waitrequest_ff && byteenable[0];

    // Map the addressed window and its pointer onto a storage slot.
    always_comb begin
        slot_hit = 1'b0;
        slot_sel = rtc_window_pkg::SLOT_SECOND;
        if (address == ADDR_TIME_LOW) begin
            slot_hit = 1'b1;
            case (time_window_pointer_ff)
                rtc_window_pkg::PTR_00: slot_sel = rtc_window_pkg::SLOT_SECOND;
                rtc_window_pkg::PTR_01: slot_sel = rtc_window_pkg::SLOT_HOUR;
                rtc_window_pkg::PTR_10: slot_sel = rtc_window_pkg::SLOT_DAY;
                default:                slot_sel = rtc_window_pkg::SLOT_YEAR;
            endcase
        end else if (address == ADDR_TIME_HIGH) begin
            case (time_window_pointer_ff)
                rtc_window_pkg::PTR_00: begin
                    slot_hit = 1'b1;
                    slot_sel = rtc_window_pkg::SLOT_MINUTE;
                end
                rtc_window_pkg::PTR_01: begin
                    slot_hit = 1'b1;
                    slot_sel = rtc_window_pkg::SLOT_WEEKDAY;
                end
                rtc_window_pkg::PTR_10: begin
                    slot_hit = 1'b1;
                    slot_sel = rtc_window_pkg::SLOT_MONTH;
                end
                default: slot_hit = 1'b0;
            endcase
        end else if (address == ADDR_ALARM_LOW) begin
            case (alarm_window_pointer_ff)
                rtc_window_pkg::PTR_01: begin
                    slot_hit = 1'b1;
                    slot_sel = rtc_window_pkg::SLOT_A_HOUR;
                end
                rtc_window_pkg::PTR_10: begin
                    slot_hit = 1'b1;
                    slot_sel = rtc_window_pkg::SLOT_A_DAY;
                end
                default: slot_hit = 1'b0;
            endcase
        end else if (address == ADDR_ALARM_HIGH) begin
            case (alarm_window_pointer_ff)
                rtc_window_pkg::PTR_01: begin
                    slot_hit = 1'b1;
                    slot_sel = rtc_window_pkg::SLOT_A_WEEKDAY;
                end
                rtc_window_pkg::PTR_10: begin
                    slot_hit = 1'b1;
                    slot_sel = rtc_window_pkg::SLOT_A_MONTH;
                end
                default: slot_hit = 1'b0;
            endcase
        end
    end

    // Read data: selected slot, control word, or zero for anything unmapped.
    always_comb begin
        nxt_readdata = 32'h0000_0000;
        if (slot_hit) begin
            nxt_readdata[7:0] = value_ff[slot_sel] & rtc_window_pkg::SLOT_MASK[slot_sel];
        end else if (address == ADDR_CONTROL) begin
            nxt_readdata[rtc_window_pkg::CTL_TPTR_LSB +: 2] = time_window_pointer_ff;
            nxt_readdata[rtc_window_pkg::CTL_APTR_LSB +: 2] = alarm_window_pointer_ff;
            nxt_readdata[rtc_window_pkg::CTL_UNLOCK_BIT]    = value_write_unlock_ff;
        end
    end

    // One wait cycle per request; waitrequest returns high right after completion.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            waitrequest_ff <= 1'b1;
        end else begin
            waitrequest_ff <= !((read || write) && waitrequest_ff);
        end
    end

    // Read data is captured while waiting, before the pointer can move.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            readdata_ff <= 32'h0000_0000;
        end else if (read && waitrequest_ff) begin
            readdata_ff <= nxt_readdata;
        end
    end

    // Unlock bit; the protective unlock sequence lives outside this block.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            value_write_unlock_ff <= rtc_window_pkg::UNLOCK_RESET;
        end else if (write_done && address == ADDR_CONTROL) begin
            value_write_unlock_ff <= writedata[rtc_window_pkg::CTL_UNLOCK_BIT];
        end
    end

    // Pointers step down after each high window access and hold at 00.
    always_comb begin
        nxt_time_window_pointer  = time_window_pointer_ff;
        nxt_alarm_window_pointer = alarm_window_pointer_ff;
        if (write_done && address == ADDR_CONTROL) begin
            nxt_time_window_pointer  = writedata[rtc_window_pkg::CTL_TPTR_LSB +: 2];
            nxt_alarm_window_pointer = writedata[rtc_window_pkg::CTL_APTR_LSB +: 2];
        end else if (access_done && address == ADDR_TIME_HIGH &&
                     time_window_pointer_ff != rtc_window_pkg::PTR_00) begin
            nxt_time_window_pointer = time_window_pointer_ff - 2'h1;
        end else if (access_done && address == ADDR_ALARM_HIGH &&
                     alarm_window_pointer_ff != rtc_window_pkg::PTR_00) begin
            nxt_alarm_window_pointer = alarm_window_pointer_ff - 2'h1;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            time_window_pointer_ff  <= rtc_window_pkg::PTR_RESET;
            alarm_window_pointer_ff <= rtc_window_pkg::PTR_RESET;
        end else begin
            time_window_pointer_ff  <= nxt_time_window_pointer;
            alarm_window_pointer_ff <= nxt_alarm_window_pointer;
        end
    end

    // Each slot stores only its implemented bits, so unused bits can never read back set.
    // A locked write still completes on the bus; it just leaves the value alone.
    generate
        for (genvar g = 0; g < rtc_window_pkg::NUM_SLOTS; g++) begin : g_slot
            always_ff @(posedge clock or posedge reset) begin
                if (reset) begin
                    value_ff[g] <= rtc_window_pkg::VALUE_RESET;
                end else if (write_done && slot_hit && slot_sel == 4'(g) && value_write_unlock_ff) begin
                    value_ff[g] <= writedata[7:0] & rtc_window_pkg::SLOT_MASK[g];
                end
            end
        end
    endgenerate

    // Stored fields keep their unused upper bits clear.
    a_month_bits: assert property (@(posedge clock) disable iff (reset)
        value_ff[rtc_window_pkg::SLOT_MONTH][7:5] == 3'h0)
        else $error("Month upper bits set.");
    a_day_bits: assert property (@(posedge clock) disable iff (reset)
        value_ff[rtc_window_pkg::SLOT_DAY][7:6] == 2'h0)
        else $error("Day upper bits set.");
    a_weekday_bits: assert property (@(posedge clock) disable iff (reset)
        value_ff[rtc_window_pkg::SLOT_WEEKDAY][7:3] == 5'h00)
        else $error("Weekday upper bits set.");
    a_hour_bits: assert property (@(posedge clock) disable iff (reset)
        value_ff[rtc_window_pkg::SLOT_HOUR][7:6] == 2'h0)
        else $error("Hour upper bits set.");
    a_minute_bits: assert property (@(posedge clock) disable iff (reset)
        value_ff[rtc_window_pkg::SLOT_MINUTE][7] == 1'b0)
        else $error("Minute bit 7 set.");
    a_second_bits: assert property (@(posedge clock) disable iff (reset)
        value_ff[rtc_window_pkg::SLOT_SECOND][7] == 1'b0)
        else $error("Second bit 7 set.");
    a_alarm_bits: assert property (@(posedge clock) disable iff (reset)
        value_ff[rtc_window_pkg::SLOT_A_MONTH][7:5] == 3'h0 &&
        value_ff[rtc_window_pkg::SLOT_A_DAY][7:6] == 2'h0 &&
        value_ff[rtc_window_pkg::SLOT_A_HOUR][7:6] == 2'h0)
        else $error("Alarm upper bits set.");

    // Unlocked writes store the written byte, cut to the implemented bits of the slot.
    a_year_write: assert property (@(posedge clock) disable iff (reset)
        (write_done && value_write_unlock_ff && address == ADDR_TIME_LOW && time_window_pointer_ff == 2'h3)
        |=> (value_ff[rtc_window_pkg::SLOT_YEAR] == $past(wr_byte)))
        else $error("Year write not stored.");
    a_second_write: assert property (@(posedge clock) disable iff (reset)
        (write_done && value_write_unlock_ff && address == ADDR_TIME_LOW && time_window_pointer_ff == 2'h0)
        |=> (value_ff[rtc_window_pkg::SLOT_SECOND] == ($past(wr_byte) & rtc_window_pkg::MASK_SECOND)))
        else $error("Seconds write not stored.");
    a_hour_write: assert property (@(posedge clock) disable iff (reset)
        (write_done && value_write_unlock_ff && address == ADDR_TIME_LOW && time_window_pointer_ff == 2'h1)
        |=> (value_ff[rtc_window_pkg::SLOT_HOUR] == ($past(wr_byte) & rtc_window_pkg::MASK_HOUR)))
        else $error("Hours write not stored.");
    a_minute_write: assert property (@(posedge clock) disable iff (reset)
        (write_done && value_write_unlock_ff && address == ADDR_TIME_HIGH && time_window_pointer_ff == 2'h0)
        |=> (value_ff[rtc_window_pkg::SLOT_MINUTE] == ($past(wr_byte) & rtc_window_pkg::MASK_MINUTE)))
        else $error("Minutes write not stored.");
    a_weekday_write: assert property (@(posedge clock) disable iff (reset)
        (write_done && value_write_unlock_ff && address == ADDR_TIME_HIGH && time_window_pointer_ff == 2'h1)
        |=> (value_ff[rtc_window_pkg::SLOT_WEEKDAY] == ($past(wr_byte) & rtc_window_pkg::MASK_WEEKDAY)))
        else $error("Weekday write not stored.");
    a_month_write: assert property (@(posedge clock) disable iff (reset)
        (write_done && value_write_unlock_ff && address == ADDR_TIME_HIGH && time_window_pointer_ff == 2'h2)
        |=> (value_ff[rtc_window_pkg::SLOT_MONTH] == ($past(wr_byte) & rtc_window_pkg::MASK_MONTH)))
        else $error("Month write not stored.");
    a_alarm_day_write: assert property (@(posedge clock) disable iff (reset)
        (write_done && value_write_unlock_ff && address == ADDR_ALARM_LOW && alarm_window_pointer_ff == 2'h2)
        |=> (value_ff[rtc_window_pkg::SLOT_A_DAY] == ($past(wr_byte) & rtc_window_pkg::MASK_DAY)))
        else $error("Alarm day write not stored.");

    // The unlock bit follows each control write that reaches the low lane.
    a_unlock_set: assert property (@(posedge clock) disable iff (reset)
        (write_done && address == ADDR_CONTROL && wr_byte[rtc_window_pkg::CTL_UNLOCK_BIT])
        |=> value_write_unlock_ff)
        else $error("Unlock bit not set.");
    a_unlock_clear: assert property (@(posedge clock) disable iff (reset)
        (write_done && address == ADDR_CONTROL && !wr_byte[rtc_window_pkg::CTL_UNLOCK_BIT])
        |=> !value_write_unlock_ff)
        else $error("Unlock bit not cleared.");

    // A read of the low time window at pointer 11 returns the year.
    a_year_read: assert property (@(posedge clock) disable iff (reset)
        (read && waitrequest_ff && address == ADDR_TIME_LOW && time_window_pointer_ff == 2'h3)
        |=> (readdata_ff == {24'h000000, value_ff[rtc_window_pkg::SLOT_YEAR]}))
        else $error("Year not shown in low time window.");

    // High time window reads zero in the reserved position.
    a_reserved_zero: assert property (@(posedge clock) disable iff (reset)
        (read && waitrequest_ff && address == ADDR_TIME_HIGH && time_window_pointer_ff == 2'h3)
        |=> (readdata_ff == 32'h0000_0000))
        else $error("Reserved time byte not zero.");

    // Alarm windows hold no byte at pointers 00 and 11, so they read zero there.
    a_alarm_empty: assert property (@(posedge clock) disable iff (reset)
        (read && waitrequest_ff && (address == ADDR_ALARM_LOW || address == ADDR_ALARM_HIGH) &&
         (alarm_window_pointer_ff == 2'h0 || alarm_window_pointer_ff == 2'h3))
        |=> (readdata_ff == 32'h0000_0000))
        else $error("Empty alarm byte not zero.");

    // Locked writes leave the year, month, day, hour and weekday values untouched.
    a_time_locked: assert property (@(posedge clock) disable iff (reset)
        (write_done && !value_write_unlock_ff &&
         (address == ADDR_TIME_LOW || address == ADDR_TIME_HIGH))
        |=> ($stable(value_ff[rtc_window_pkg::SLOT_YEAR]) && $stable(value_ff[rtc_window_pkg::SLOT_MONTH]) &&
             $stable(value_ff[rtc_window_pkg::SLOT_DAY]) && $stable(value_ff[rtc_window_pkg::SLOT_HOUR]) &&
             $stable(value_ff[rtc_window_pkg::SLOT_WEEKDAY])))
        else $error("Locked time write changed a value.");

    // Locked writes leave the alarm values untouched.
    a_alarm_locked: assert property (@(posedge clock) disable iff (reset)
        (write_done && !value_write_unlock_ff &&
         (address == ADDR_ALARM_LOW || address == ADDR_ALARM_HIGH))
        |=> ($stable(value_ff[rtc_window_pkg::SLOT_A_MONTH]) && $stable(value_ff[rtc_window_pkg::SLOT_A_DAY]) &&
             $stable(value_ff[rtc_window_pkg::SLOT_A_HOUR]) &&
             $stable(value_ff[rtc_window_pkg::SLOT_A_WEEKDAY])))
        else $error("Locked alarm write changed a value.");

    // The pointers step down by exactly one after a high window access, except at 00 where they hold.
    a_time_ptr_step: assert property (@(posedge clock) disable iff (reset)
        (access_done && address == ADDR_TIME_HIGH)
        |=> (time_window_pointer_ff == (($past(time_window_pointer_ff) == 2'h0) ? 2'h0 :
                                        $past(time_window_pointer_ff) - 2'h1)))
        else $error("Time pointer did not step down.");
    a_alarm_ptr_step: assert property (@(posedge clock) disable iff (reset)
        (access_done && address == ADDR_ALARM_HIGH)
        |=> (alarm_window_pointer_ff == (($past(alarm_window_pointer_ff) == 2'h0) ? 2'h0 :
                                         $past(alarm_window_pointer_ff) - 2'h1)))
        else $error("Alarm pointer did not step down.");

    // Pointers move only on a high window access or a control write; a stray step would skip a byte.
    a_tptr_hold: assert property (@(posedge clock) disable iff (reset)
        (!(access_done && address == ADDR_TIME_HIGH) && !(write_done && address == ADDR_CONTROL))
        |=> $stable(time_window_pointer_ff))
        else $error("Time pointer moved without an access.");
    a_aptr_hold: assert property (@(posedge clock) disable iff (reset)
        (!(access_done && address == ADDR_ALARM_HIGH) && !(write_done && address == ADDR_CONTROL))
        |=> $stable(alarm_window_pointer_ff))
        else $error("Alarm pointer moved without an access.");

    // Every request sees waitrequest low one edge after it is first seen.
    a_wait_answer: assert property (@(posedge clock) disable iff (reset)
        ((read || write) && waitrequest_ff) |=> !waitrequest_ff ##1 waitrequest_ff)
        else $error("Bus answer timing wrong.");

    // Waitrequest rests high, so every request waits exactly once.
    a_wait_idle: assert property (@(posedge clock) disable iff (reset)
        (!read && !write) |=> waitrequest_ff)
        else $error("Waitrequest low without a request.");

    // Read data carries one byte and stands until the next read is seen.
    a_rdata_upper: assert property (@(posedge clock) disable iff (reset)
        readdata_ff[31:8] == 24'h000000)
        else $error("Read data upper bits set.");
    a_rdata_hold: assert property (@(posedge clock) disable iff (reset)
        !(read && waitrequest_ff) |=> $stable(readdata_ff))
        else $error("Read data changed without a read.");

endmodule

// [tb/cpu_master.sv]
`timescale 1ns/1ps
// Bus master standing in for the processor core that reaches the window registers.
module cpu_master (
    input  wire logic        clock,
    output logic      [13:0] address,
    output logic             read,
    output logic             write,
    output logic      [31:0] writedata,
    output logic      [3:0]  byteenable,
    input  wire logic [31:0] readdata,
    input  wire logic        waitrequest
);
    // The master starts idle so that nothing is requested while reset is applied.
    initial begin
        address    = 14'h0000;
        read       = 1'b0;
        write      = 1'b0;
        writedata  = 32'h00000000;
        byteenable = 4'h0;
    end

    // One access, called just after a rising edge; the request is held until waitrequest is low at an edge.
    // Waitrequest and read data are taken at the rising edge itself, before the slave's registers move.
    task automatic access(input logic [13:0] a, input logic is_wr, input logic [7:0] d,
                          input logic [3:0] be, output logic [31:0] q);
        address    <= a;
        read       <= ~is_wr;
        write      <= is_wr;
        writedata  <= {24'h000000, d};
        byteenable <= be;
        do begin
            @(posedge clock);
        end while (waitrequest !== 1'b0);
        q = readdata;
        // Released write data is inverted so a stale value can never pass for a fresh one.
        read      <= 1'b0;
        write     <= 1'b0;
        writedata <= ~{24'h000000, d};
        @(posedge clock);
    endtask
endmodule

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
    localparam int W = rtc_window_pkg::BYTES_PER_WORD;
    localparam logic [13:0] A_CTL = 14'(rtc_window_pkg::IDX_CONTROL * W);
    logic [13:0] a_lo [2] = '{14'(rtc_window_pkg::IDX_TIME_LOW * W), 14'(rtc_window_pkg::IDX_ALARM_LOW * W)};
    logic [13:0] a_hi [2] = '{14'(rtc_window_pkg::IDX_TIME_HIGH * W), 14'(rtc_window_pkg::IDX_ALARM_HIGH * W)};
    // Implemented bits per window and pointer; zero marks a reserved or missing byte.
    logic [7:0] lo_mask [2][4] = '{'{8'h7F, 8'h3F, 8'h3F, 8'hFF}, '{8'h00, 8'h3F, 8'h3F, 8'h00}};
    logic [7:0] hi_mask [2][4] = '{'{8'h7F, 8'h07, 8'h1F, 8'h00}, '{8'h00, 8'h07, 8'h1F, 8'h00}};
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic [13:0] address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
    logic [31:0] readdata;
    logic        waitrequest;
    logic [31:0] q;
    logic [7:0]  c;
    int          num_errors = 0;
    int          n_compared = 0;

    // A 4 ns clock period.
    always #2 clock = ~clock;

    rtc_value_window u_dut (
        .clock       (clock),
        .reset       (reset),
        .address     (address),
        .read        (read),
        .write       (write),
        .writedata   (writedata),
        .byteenable  (byteenable),
        .readdata    (readdata),
        .waitrequest (waitrequest)
    );

    cpu_master u_cpu (
        .clock       (clock),
        .address     (address),
        .read        (read),
        .write       (write),
        .writedata   (writedata),
        .byteenable  (byteenable),
        .readdata    (readdata),
        .waitrequest (waitrequest)
    );

    // Comparison of a seen value against the value worked out here.
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [13:0] a, input logic [7:0] d);
        logic [31:0] r;
        u_cpu.access(a, 1'b1, d, 4'hF, r);
    endtask

    task automatic rd(input string name, input logic [13:0] a, input logic [7:0] e);
        logic [31:0] r;
        u_cpu.access(a, 1'b0, 8'h00, 4'hF, r);
        chk(name, r, {24'h000000, e});
    endtask

    // The single closing point of the run.
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Watchdog sized well above the few hundred cycles the sequence needs.
    initial begin
        #40000;
        num_errors++;
        $display("[ERR] watchdog expected done seen hang");
        end_sim();
    end

    initial begin
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        chk("wait idle", 32'(waitrequest), 32'h0000_0001);
        rd("control reset", A_CTL, 8'h00);
        rd("seconds reset", a_lo[0], 8'h00);
        // Locked: a year write must leave the stored value alone.
        wr(A_CTL, 8'h03);
        wr(a_lo[0], 8'h99);
        rd("locked year", a_lo[0], 8'h00);
        // Unlocked: fill every slot of both windows and watch the pointer step after high accesses.
        for (int w = 0; w < 2; w++) begin
            for (int p = 0; p < 4; p++) begin
                c = 8'h10 | (w == 1 ? 8'(p << 2) : 8'(p));
                wr(A_CTL, c);
                wr(a_lo[w], 8'(8'hF0 | (p + 1)));
                wr(a_hi[w], 8'(8'hE0 | (p + 5)));
                rd("pointer step", A_CTL, (p == 0) ? c : c - (w == 1 ? 8'h04 : 8'h01));
            end
        end
        // Read back through each pointer value; unimplemented bits of every byte come back zero.
        for (int w = 0; w < 2; w++) begin
            for (int p = 0; p < 4; p++) begin
                wr(A_CTL, 8'h10 | (w == 1 ? 8'(p << 2) : 8'(p)));
                rd("low window", a_lo[w], 8'(8'hF0 | (p + 1)) & lo_mask[w][p]);
                rd("high window", a_hi[w], 8'(8'hE0 | (p + 5)) & hi_mask[w][p]);
            end
        end
        // Reads of the high window step the pointer down and stop at zero.
        wr(A_CTL, 8'h12);
        for (int p = 2; p >= 0; p--) begin
            rd("high read walk", a_hi[0], 8'(8'hE0 | (p + 5)) & hi_mask[0][p]);
        end
        rd("pointer floor", A_CTL, 8'h10);
        // Locked alarm write is ignored.
        wr(A_CTL, 8'h08);
        wr(a_lo[1], 8'h00);
        rd("locked alarm day", a_lo[1], 8'h33);
        // A write with the low byte lane disabled changes nothing, even when unlocked.
        wr(A_CTL, 8'h18);
        u_cpu.access(a_lo[1], 1'b1, 8'h00, 4'h0, q);
        rd("lane off alarm day", a_lo[1], 8'h33);
        // Unmapped place reads zero and ignores writes.
        wr(14'h0100, 8'h5A);
        rd("unmapped", 14'h0100, 8'h00);
        // A second reset mid-run clears pointers, unlock and stored values.
        reset <= 1'b1;
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        chk("wait after reset", 32'(waitrequest), 32'h0000_0001);
        rd("control after reset", A_CTL, 8'h00);
        rd("seconds after reset", a_lo[0], 8'h00);
        end_sim();
    end
endmodule
